// ===== shared/eeprom_access_defines.vh
/*
 Constants for the EEPROM access control block: I/O offsets of its
 registers, control field positions, reset values and timing counts.
 Assumes it is included by bare name from the design file.
*/
`ifndef EEPROM_ACCESS_DEFINES_VH
`define EEPROM_ACCESS_DEFINES_VH

// I/O space offsets
`define EE_CTRL_OFF 6'h1C
`define EE_DATA_OFF 6'h1D
`define EE_ADRL_OFF 6'h1E
`define EE_ADRH_OFF 6'h1F

// control register fields
`define EE_RD_BIT 0
`define EE_WR_BIT 1
`define EE_ARM_BIT 2
`define EE_RIE_BIT 3

// reset values
`define EE_CTRL_RST 1'h0
`define EE_ADDR_RST 10'h000
`define EE_DATA_RST 8'h00

// timing counts in CPU cycles
`define EE_ARM_CYCLES 3'h4
`define EE_WR_STALL 3'h2
`define EE_RD_STALL 3'h4

// write time in calibrated 1 MHz oscillator cycles
`define EE_WR_OSC_CYCLES 8448

`endif

// ===== verilog/eeprom_access_control.v
/*
 EEPROM access control: control, data and address registers in the
 I/O space, a 1024 byte cell array, read and self-timed write paths,
 the ready interrupt level and the CPU stall.
 Assumes a core that gives one-cycle I/O write and read strobes, a
 free running 1 MHz calibrated oscillator on OSC_1MHZ, and a separate
 power-on reset that only falls when supply is lost.
*/
`timescale 1ns/1ns
`include "eeprom_access_defines.vh"

// Contract
// - control bits 7..4 always read zero
// - bit 3 enables the ready interrupt
// - ready interrupt is a level while idle
// - arm then strobe within four cycles writes
// - strobe without arm performs no write
// - hardware clears arm four cycles after set
// - no write while self programming is active
// - write strobe held until write time ends
// - write start stalls the CPU two cycles
// - read strobe loads data, stalls four cycles
// - busy write blocks reads and address changes
// - write timed by 8448 oscillator cycles
// - write finishes and holds power-down while busy
// - write survives reset, cleared only by power-on
// - ten bit address selects 1024 linear cells
// - data register holds write byte or read byte
module eeprom_access_control #(
   parameter WRITE_OSC_CYCLES = `EE_WR_OSC_CYCLES
) (
   // clock and resets
   input wire CLK,
   input wire RST_N,
   input wire POR_N,
   // I/O register port from the core
   input wire [5:0] IO_ADDR,
   input wire IO_WR,
   input wire IO_RD,
   input wire [7:0] IO_WDATA,
   output reg [7:0] IO_RDATA,
   // core handshakes
   output reg CPU_STALL,
   output reg READY_IRQ,
   input wire SELF_PROGRAM_ACTIVE,
   // timing oscillator and sleep
   input wire OSC_1MHZ,
   input wire SLEEP_PWRDN,
   output reg PWRDN_HOLD
);

   // true when an I/O access targets the given offset
   function hit;
      input [5:0] addr;
      input [5:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // reset release, two stages each
   reg rst_s1_q;
   reg rst_s2_q;
   reg por_s1_q;
   reg por_s2_q;
   wire rst_n_int;
   wire por_n_int;

   // register file state
   reg ready_irq_enable_q;
   reg master_write_arm_q;
   reg [2:0] arm_cnt_q;
   reg [9:0] cell_address_reg_q;
   reg [7:0] cell_data_reg_q;
   reg [2:0] stall_cnt_q;

   // write engine state, kept across a plain reset
   reg write_strobe_q;
   reg [13:0] osc_cnt_q;
   reg [9:0] wr_addr_q;
   reg [7:0] wr_data_q;
   reg [7:0] cells [0:1023];

   // oscillator sampling
   reg osc_s1_q;
   reg osc_s2_q;
   reg osc_s3_q;
   reg osc_lvl_q;
   wire osc_tick;

   // decoded accesses
   wire ctrl_wr;
   wire rd_req;
   wire wr_req;
   wire wr_start;
   wire rd_go;
   wire wr_done;
   reg [7:0] rd_mux;

   // synchronous release of the reset
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_q <= 1'h0;
         rst_s2_q <= 1'h0;
      end else begin
         rst_s1_q <= 1'h1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // power-on reset release, separate so a write outlives RST_N
   always @(posedge CLK or negedge POR_N) begin
      if (!POR_N) begin
         por_s1_q <= 1'h0;
         por_s2_q <= 1'h0;
      end else begin
         por_s1_q <= 1'h1;
         por_s2_q <= por_s1_q;
      end
   end

   assign rst_n_int = rst_s2_q;
   assign por_n_int = por_s2_q;

   // three stage sampling of the oscillator, first stage read only by second
   always @(posedge CLK or negedge por_n_int) begin
      if (!por_n_int) begin
         osc_s1_q <= 1'h0;
         osc_s2_q <= 1'h0;
         osc_s3_q <= 1'h0;
         osc_lvl_q <= 1'h0;
      end else begin
         osc_s1_q <= OSC_1MHZ;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         if (osc_s2_q == osc_s3_q) begin
            osc_lvl_q <= osc_s3_q;
         end
      end
   end

   // a rising edge counts once the last two stages agree
   assign osc_tick = osc_s2_q & osc_s3_q & ~osc_lvl_q;

   // request decode
   assign ctrl_wr = IO_WR & hit(IO_ADDR, `EE_CTRL_OFF);
   assign rd_req = ctrl_wr & IO_WDATA[`EE_RD_BIT];
   assign wr_req = ctrl_wr & IO_WDATA[`EE_WR_BIT];
   // arm must already stand; arm written in the same access does not count
   assign wr_start = wr_req & master_write_arm_q & ~write_strobe_q
      & ~SELF_PROGRAM_ACTIVE & rst_n_int;
   assign rd_go = rd_req & ~write_strobe_q;
   assign wr_done = write_strobe_q & osc_tick
      & (osc_cnt_q == WRITE_OSC_CYCLES[13:0] - 14'h0001);

   // write engine on power-on reset only
   always @(posedge CLK or negedge por_n_int) begin
      if (!por_n_int) begin
         write_strobe_q <= 1'h0;
         osc_cnt_q <= 14'h0000;
         wr_addr_q <= `EE_ADDR_RST;
         wr_data_q <= `EE_DATA_RST;
      end else if (wr_start) begin
         // capture cell and byte, start timing
         write_strobe_q <= 1'h1;
         osc_cnt_q <= 14'h0000;
         wr_addr_q <= cell_address_reg_q;
         wr_data_q <= cell_data_reg_q;
      end else if (wr_done) begin
         write_strobe_q <= 1'h0;
         osc_cnt_q <= 14'h0000;
      end else if (write_strobe_q && osc_tick) begin
         osc_cnt_q <= osc_cnt_q + 14'h0001;
      end
   end

   // the cell array commits the byte when the write time expires
   always @(posedge CLK) begin
      if (wr_done) begin
         cells[wr_addr_q] <= wr_data_q;
      end
   end

   // control bits and arm timeout
   always @(posedge CLK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         ready_irq_enable_q <= `EE_CTRL_RST;
         master_write_arm_q <= `EE_CTRL_RST;
         arm_cnt_q <= 3'h0;
      end else begin
         if (ctrl_wr) begin
            ready_irq_enable_q <= IO_WDATA[`EE_RIE_BIT];
         end
         if (ctrl_wr && IO_WDATA[`EE_ARM_BIT]) begin
            // arm stands for exactly four cycles
            master_write_arm_q <= 1'h1;
            arm_cnt_q <= `EE_ARM_CYCLES - 3'h1;
         end else if (ctrl_wr && !IO_WDATA[`EE_ARM_BIT]) begin
            master_write_arm_q <= 1'h0;
            arm_cnt_q <= 3'h0;
         end else if (master_write_arm_q) begin
            if (arm_cnt_q == 3'h0) begin
               master_write_arm_q <= 1'h0;
            end else begin
               arm_cnt_q <= arm_cnt_q - 3'h1;
            end
         end
      end
   end

   // address and data registers
   always @(posedge CLK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         cell_address_reg_q <= `EE_ADDR_RST;
         cell_data_reg_q <= `EE_DATA_RST;
      end else begin
         // address frozen while a write runs
         if (IO_WR && hit(IO_ADDR, `EE_ADRL_OFF) && !write_strobe_q) begin
            cell_address_reg_q[7:0] <= IO_WDATA;
         end
         if (IO_WR && hit(IO_ADDR, `EE_ADRH_OFF) && !write_strobe_q) begin
            cell_address_reg_q[9:8] <= IO_WDATA[1:0];
         end
         // the read result lands within the strobe's own access
         if (rd_go) begin
            cell_data_reg_q <= cells[cell_address_reg_q];
         end else if (IO_WR && hit(IO_ADDR, `EE_DATA_OFF)) begin
            cell_data_reg_q <= IO_WDATA;
         end
      end
   end

   // CPU stall counter; a read wins if both strobes come together
   always @(posedge CLK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         stall_cnt_q <= 3'h0;
         CPU_STALL <= 1'h0;
      end else begin
         if (rd_go) begin
            stall_cnt_q <= `EE_RD_STALL - 3'h1;
            CPU_STALL <= 1'h1;
         end else if (wr_start) begin
            stall_cnt_q <= `EE_WR_STALL - 3'h1;
            CPU_STALL <= 1'h1;
         end else if (stall_cnt_q != 3'h0) begin
            stall_cnt_q <= stall_cnt_q - 3'h1;
            CPU_STALL <= 1'h1;
         end else begin
            CPU_STALL <= 1'h0;
         end
      end
   end

   // read data mux; unmapped offsets read zero
   always @* begin
      rd_mux = 8'h00;
      if (hit(IO_ADDR, `EE_CTRL_OFF)) begin
         // upper nibble reserved
         rd_mux = {4'h0, ready_irq_enable_q, master_write_arm_q,
            write_strobe_q, 1'h0};
      end else if (hit(IO_ADDR, `EE_DATA_OFF)) begin
         rd_mux = cell_data_reg_q;
      end else if (hit(IO_ADDR, `EE_ADRL_OFF)) begin
         rd_mux = cell_address_reg_q[7:0];
      end else if (hit(IO_ADDR, `EE_ADRH_OFF)) begin
         rd_mux = {6'h00, cell_address_reg_q[9:8]};
      end
   end

   // registered read port, one cycle after the read strobe
   always @(posedge CLK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         IO_RDATA <= 8'h00;
      end else if (IO_RD) begin
         IO_RDATA <= rd_mux;
      end
   end

   // ready level; the core still gates it with its global enable
   always @(posedge CLK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         READY_IRQ <= 1'h0;
      end else begin
         READY_IRQ <= ready_irq_enable_q & ~write_strobe_q & ~wr_start;
      end
   end

   // power-down is held off while a write runs or the sleep overlapped it
   always @(posedge CLK or negedge por_n_int) begin
      if (!por_n_int) begin
         PWRDN_HOLD <= 1'h0;
      end else if (write_strobe_q && !wr_done) begin
         PWRDN_HOLD <= 1'h1;
      end else if (!SLEEP_PWRDN) begin
         PWRDN_HOLD <= 1'h0;
      end
   end

endmodule

// ===== testbench/eeprom_access_sva.sv
/* checker on the eeprom access block ports
   assumes bind to eeprom_access_control, one clock */
`timescale 1ns/1ns
module eeprom_access_sva (
   // clock and resets
   input wire CLK,
   input wire RST_N,
   input wire POR_N,
   // io port
   input wire [5:0] IO_ADDR,
   input wire IO_WR,
   input wire IO_RD,
   input wire [7:0] IO_WDATA,
   input wire [7:0] IO_RDATA,
   // core side levels
   input wire CPU_STALL,
   input wire READY_IRQ,
   input wire SELF_PROGRAM_ACTIVE,
   input wire SLEEP_PWRDN,
   input wire PWRDN_HOLD
);
   reg [2:0] age_q = 3'h7;
   wire ctl = IO_WR && IO_ADDR == 6'h1C;
   wire idle = !PWRDN_HOLD && !CPU_STALL && !SELF_PROGRAM_ACTIVE;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // cycles since the last arm write, saturating
   always @(posedge CLK) begin
      if (ctl && IO_WDATA[2]) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
   end
   sequence s_arm; ctl && IO_WDATA[2:1] == 2'b10; endsequence
   sequence s_go; ctl && IO_WDATA[2:1] == 2'b01 && idle; endsequence
   chk_rsv_zero: assert property (IO_RD && IO_ADDR == 6'h1C |=> IO_RDATA[7:4] == 4'h0)
      else $error("reserved bits set");
   chk_wr_stall: assert property (s_arm ##2 s_go |=> CPU_STALL [*2] ##1 !CPU_STALL)
      else $error("write stall wrong");
   chk_irq_drop: assert property (s_arm ##2 s_go |-> ##[1:2] !READY_IRQ)
      else $error("irq kept while busy");
   chk_busy_hold: assert property (s_arm ##2 s_go |-> ##[1:2] PWRDN_HOLD)
      else $error("no busy hold");
   chk_no_arm: assert property (ctl && IO_WDATA[1:0] == 2'b10 && age_q > 3'h3 && idle
      |=> !CPU_STALL && !PWRDN_HOLD)
      else $error("write without arm");
   chk_arm_clear: assert property (IO_RD && IO_ADDR == 6'h1C && age_q > 3'h4
      |=> !IO_RDATA[2])
      else $error("arm not cleared");
   chk_rd_stall: assert property (ctl && IO_WDATA[1:0] == 2'b01 && idle
      |=> CPU_STALL [*4] ##1 !CPU_STALL)
      else $error("read stall wrong");
   chk_busy_read: assert property (ctl && IO_WDATA[1:0] == 2'b01 && PWRDN_HOLD
      && !SLEEP_PWRDN && !$past(SLEEP_PWRDN) |=> !CPU_STALL)
      else $error("read while busy");
   chk_hold_fall: assert property (@(posedge CLK) disable iff (!POR_N)
      $fell(PWRDN_HOLD) |-> !$past(SLEEP_PWRDN))
      else $error("hold dropped in sleep");
endmodule
bind eeprom_access_control eeprom_access_sva u_sva (.CLK, .RST_N, .POR_N, .IO_ADDR,
   .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA, .CPU_STALL, .READY_IRQ, .SELF_PROGRAM_ACTIVE,
   .SLEEP_PWRDN, .PWRDN_HOLD);

// ===== testbench/core_io_model.sv
/* core side of the io port: one-cycle strobes
   assumes the block samples on the rising edge */
`timescale 1ns/1ns
module core_io_model (
   // clock
   input wire clk,
   // io port
   output logic [5:0] addr = 6'h00,
   output logic io_wr = 1'b0,
   output logic io_rd = 1'b0,
   output logic [7:0] wdata = 8'h00,
   input wire [7:0] rdata
);
   // strobe one cycle, address and data inverted once released
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
      addr = ~a;
      wdata = ~v;
   endtask
   // read data taken once the sampling edge has passed
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge clk);
      addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      addr = ~a;
      v = rdata;
   endtask
endmodule

// ===== testbench/eeprom_access_control_tb_top.sv
/* register level bench for the eeprom access block
   assumes the core model and checker files compile first */
`timescale 1ns/1ns
module eeprom_access_control_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, spa = 1'b0, osc = 1'b0, slp = 1'b0;
   wire [5:0] a;
   wire w, r, stall, irq, hold;
   wire [7:0] d, q;
   logic [7:0] v;
   int n_fail = 0, n_checks = 0, cyc = 0, t;
   eeprom_access_control #(.WRITE_OSC_CYCLES(4)) u_dut (.CLK(clk), .RST_N(rst_n),
      .POR_N(por_n), .IO_ADDR(a), .IO_WR(w), .IO_RD(r), .IO_WDATA(d), .IO_RDATA(q),
      .CPU_STALL(stall), .READY_IRQ(irq), .SELF_PROGRAM_ACTIVE(spa), .OSC_1MHZ(osc),
      .SLEEP_PWRDN(slp), .PWRDN_HOLD(hold));
   core_io_model u_core (.clk(clk), .addr(a), .io_wr(w), .io_rd(r), .wdata(d), .rdata(q));
   // clocks: core at 250 MHz, timing oscillator at 1 MHz
   initial forever #2 clk = ~clk;
   always #500 osc = ~osc;
   // hang guard, well above the two write times
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rdc(input logic [5:0] ad, input logic [7:0] e, input string nm);
      u_core.rd(ad, v);
      chk(nm, v, e);
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      por_n = 1'b1;
      repeat (3) @(negedge clk);
      rdc(6'h1C, 8'h00, "ctrl reset");
      rdc(6'h10, 8'h00, "unmapped");
      // top cell, irq on, full write sequence
      u_core.wr(6'h1E, 8'hFF);
      u_core.wr(6'h1F, 8'hFF);
      rdc(6'h1F, 8'h03, "addr high");
      u_core.wr(6'h1D, 8'hA5);
      u_core.wr(6'h1C, 8'h08);
      @(negedge clk);
      chk("irq idle", {7'h0, irq}, 8'h01);
      u_core.wr(6'h1C, 8'h0C);
      u_core.wr(6'h1C, 8'h0A);
      t = cyc;
      rdc(6'h1C, 8'h0A, "busy");
      chk("irq busy", {7'h0, irq}, 8'h00);
      u_core.wr(6'h1E, 8'h00);
      rdc(6'h1E, 8'hFF, "addr frozen");
      u_core.wr(6'h1C, 8'h09);
      rdc(6'h1D, 8'hA5, "busy read");
      // a new byte that a second write would pick up
      u_core.wr(6'h1D, 8'h77);
      u_core.wr(6'h1C, 8'h0C);
      u_core.wr(6'h1C, 8'h0A);
      do u_core.rd(6'h1C, v); while (v[1] !== 1'b0);
      chk("write time", {7'h0, cyc - t > 700 && cyc - t < 1100}, 8'h01);
      @(negedge clk);
      chk("irq done", {7'h0, irq}, 8'h01);
      u_core.wr(6'h1D, 8'h00);
      u_core.wr(6'h1C, 8'h01);
      rdc(6'h1D, 8'hA5, "read back");
      // strobes that must not write
      u_core.wr(6'h1D, 8'h5A);
      u_core.wr(6'h1C, 8'h02);
      rdc(6'h1C, 8'h00, "no arm");
      u_core.wr(6'h1C, 8'h04);
      rdc(6'h1C, 8'h04, "arm set");
      repeat (4) @(negedge clk);
      rdc(6'h1C, 8'h00, "arm cleared");
      u_core.wr(6'h1C, 8'h02);
      u_core.wr(6'h1C, 8'h06);
      spa = 1'b1;
      u_core.wr(6'h1C, 8'h04);
      u_core.wr(6'h1C, 8'h02);
      spa = 1'b0;
      u_core.wr(6'h1C, 8'h01);
      rdc(6'h1D, 8'hA5, "cell kept");
      // write through a reset pulse and a power-down request
      u_core.wr(6'h1E, 8'h01);
      u_core.wr(6'h1F, 8'h00);
      u_core.wr(6'h1D, 8'h3C);
      slp = 1'b1;
      u_core.wr(6'h1C, 8'h04);
      u_core.wr(6'h1C, 8'h02);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("hold", {7'h0, hold}, 8'h01);
      repeat (1200) @(negedge clk);
      chk("hold after", {7'h0, hold}, 8'h01);
      slp = 1'b0;
      repeat (3) @(negedge clk);
      chk("hold off", {7'h0, hold}, 8'h00);
      u_core.wr(6'h1E, 8'h01);
      u_core.wr(6'h1C, 8'h01);
      rdc(6'h1D, 8'h3C, "write kept");
      wrap_up();
   end
endmodule
